// >>> rtl/srd_pkg.sv
// shared constants, types and decode functions of the serial management register decoder
package srd_pkg;

  // frame geometry, in management clock bits
  localparam int          DATA_W         = 16;
  localparam int          ADDR_W         = 10;
  localparam logic [5:0]  PRE_LAST_BIT   = 6'h1f;   // 32 preamble ones, counted 0..31
  localparam logic [4:0]  OPC_LAST_BIT   = 5'h01;   // 2 opcode bits
  localparam logic [4:0]  ADDR_LAST_BIT  = 5'h09;   // 10 address bits
  localparam logic [4:0]  TA_LAST_BIT    = 5'h01;   // 2 turnaround bits
  localparam logic [4:0]  DATA_LAST_BIT  = 5'h0f;   // 16 data bits
  localparam logic [1:0]  OPC_READ       = 2'h2;
  localparam logic [1:0]  OPC_WRITE      = 2'h1;

  // address space bounds of the 10-bit register address
  localparam logic [9:0]  BASIC_END      = 10'h03f;
  localparam logic [9:0]  EXT_BEGIN      = 10'h040;
  localparam logic [9:0]  EXT_END        = 10'h09b;
  localparam logic [9:0]  CNT_BEGIN      = 10'h0a0;
  localparam logic [9:0]  CNT_END        = 10'h143;
  localparam logic [9:0]  PHY_BEGIN      = 10'h200;
  localparam logic [9:0]  PHY_END        = 10'h2ff;
  localparam logic [4:0]  PHY_FIELD      = 5'h10;   // phy-address field that opens the phy space

  // basic configuration register offsets
  localparam logic [5:0]  OFS_SIGNATURE_WORD = 6'h00, OFS_PORT0_BASIC_CTRL = 6'h01, OFS_PORT0_EXTENDED_CTRL = 6'h02,
    OFS_PORT1_EXTENDED_CTRL = 6'h02, OFS_PORT1_BASIC_CTRL = 6'h03, OFS_PORT2_EXTENDED_CTRL = 6'h04,
    OFS_PORT3_EXTENDED_CTRL = 6'h04, OFS_PORT2_BASIC_CTRL = 6'h05, OFS_PORT4_EXTENDED_CTRL = 6'h06,
    OFS_PORT5_EXTENDED_CTRL = 6'h06, OFS_PORT3_BASIC_CTRL = 6'h07, OFS_PORT4_BASIC_CTRL = 6'h08,
    OFS_PORT5_BASIC_CTRL = 6'h09, OFS_SYSTEM_CTRL_0 = 6'h0a, OFS_SYSTEM_CTRL_1 = 6'h0b, OFS_MULTICAST_SNOOPING = 6'h0c,
    OFS_ADDRESS_RESOLUTION_CTRL = 6'h0d, OFS_VLAN_PRIORITY_MAP = 6'h0e, OFS_TOS_PRIORITY_MAP = 6'h0f,
    OFS_SYSTEM_CTRL_2 = 6'h10, OFS_SYSTEM_CTRL_3 = 6'h11, OFS_SYSTEM_CTRL_4 = 6'h12,
    OFS_PORT0_SECURITY_OPTION = 6'h13, OFS_PORT1_SECURITY_OPTION = 6'h14, OFS_PORT2_SECURITY_OPTION = 6'h15,
    OFS_PORT3_SECURITY_OPTION = 6'h16, OFS_PORT4_SECURITY_OPTION = 6'h17, OFS_PORT5_SECURITY_OPTION = 6'h18,
    OFS_UNICAST_FORWARD_GROUP_MAP = 6'h19, OFS_BROADCAST_FORWARD_GROUP_MAP = 6'h1a,
    OFS_MULTICAST_FORWARD_GROUP_MAP = 6'h1b, OFS_RESERVED_DEST_FORWARD_GROUP_MAP = 6'h1c,
    OFS_PACKET_IDENT_FORWARD_GROUP_MAP = 6'h1d, OFS_VLAN_PRIO_ENABLE_GROUP_MAP = 6'h1e,
    OFS_SERVICE_PRIO_ENABLE_GROUP_MAP = 6'h1f, OFS_INPUT_FORCE_UNTAG_GROUP_MAP = 6'h20,
    OFS_INGRESS_FILTER_GROUP_MAP = 6'h21, OFS_VLAN_SECURITY_DISABLE_GROUP_MAP = 6'h22,
    OFS_BUFFER_THRESHOLD_0 = 6'h23, OFS_BUFFER_THRESHOLD_1 = 6'h24, OFS_GROUP_SNOOP_TRAP_JAM_THRESHOLD = 6'h25,
    OFS_QUEUE2_WEIGHT_VID_CHECK = 6'h26, OFS_QUEUE3_WEIGHT_TAGGED_ONLY = 6'h27,
    OFS_INPUT_DOUBLE_TAG_PORT0_VID = 6'h28, OFS_OUTPUT_DOUBLE_TAG_PORT1_VID = 6'h29,
    OFS_OUTPUT_TAG_BYPASS_PORT2_VID = 6'h2a, OFS_PORT3_PORT4_VID_HIGH = 6'h2b, OFS_RESERVED_ADDR_CTRL_PORT5_VID = 6'h2c;
  localparam logic [15:0] CFG_RESET      = 16'h0000;

  // target space of a decoded address
  typedef enum logic [1:0] {RGN_BASIC = 2'h0, RGN_EXT = 2'h1, RGN_CNT = 2'h2, RGN_PHY = 2'h3} srd_region_e;

  // frame walker states, one-hot
  typedef enum logic [7:0] {
    ST_PRE = 8'h01, ST_IDLE = 8'h02, ST_START = 8'h04, ST_OPC = 8'h08,
    ST_ADDR = 8'h10, ST_TA = 8'h20, ST_DATA = 8'h40, ST_GAP = 8'h80
  } srd_state_e;

  // access toward the spaces held outside this block
  typedef struct packed {
    logic        rd;
    logic        wr;
    srd_region_e region;
    logic [9:0]  addr;
    logic [15:0] wdata;
  } srd_ext_req_s;

  // switch events that pull the interrupt pin
  typedef struct packed {
    logic table_access;
    logic port_security;
    logic counter_overflow;
    logic port_status;
  } srd_events_s;

  // complete state of the slave
  typedef struct packed {
    srd_state_e      fsm;
    logic            mdc_s1, mdc_s2, mdc_s3;
    logic            mdio_s1, mdio_s2;
    logic            strap_s1, strap_s2;
    logic [1:0]      strap_age;
    logic            strap_taken;
    logic            mode32;
    logic [5:0]      pre_cnt;
    logic            pre_done;
    logic [4:0]      bit_cnt;
    logic [1:0]      opc;
    logic [9:0]      addr;
    logic            is_read;
    logic            hit;
    logic [15:0]     shreg;
    logic            out;
    logic            oe;
    srd_ext_req_s    ext;
    logic            int_n;
    logic [63:0][15:0] cfg;
  } srd_state_s;

  // true when the address falls inside one of the four mapped spaces
  function automatic logic srd_addr_hit(input logic [9:0] a);
    srd_addr_hit = (a <= BASIC_END) || (a >= EXT_BEGIN && a <= EXT_END) ||
                   (a >= CNT_BEGIN && a <= CNT_END) || (a >= PHY_BEGIN && a <= PHY_END);
  endfunction : srd_addr_hit

  // which space a mapped address belongs to
  function automatic srd_region_e srd_region_of(input logic [9:0] a);
    if (a <= BASIC_END) begin
      srd_region_of = RGN_BASIC;
    end else if (a <= EXT_END) begin
      srd_region_of = RGN_EXT;
    end else if (a <= CNT_END) begin
      srd_region_of = RGN_CNT;
    end else begin
      srd_region_of = RGN_PHY;
    end
  endfunction : srd_region_of

endpackage : srd_pkg

// >>> rtl/srd_smi_slave.sv
// serial management slave with 10-bit register address decode and basic configuration registers
`timescale 1ns/100ps
`default_nettype none

// Function
// R1: 16-bit management port, host-driven clock pin, one bidirectional data pin.
// R2: each command selects its register with a 10-bit address.
// R3: up to 0x03f is basic configuration; 0x040..0x09b is extended configuration.
// R4: 0x0a0..0x143 is counter and status; 0x200..0x2ff is the phy space.
// R5: host splits the address into 5-bit phy field and 5-bit register field.
// R6: phy field 10000 plus standard register number reaches port 0..4 phy registers.
// R7: width strap sampled at reset; low selects the 16-bit mode.
// R8: active-low interrupt on table, security, counter overflow and port status events.
// R9: host sends 32 ones, start 01, opcode 10 read or 01 write, address msb first.
// R10: two turnaround bits precede the 16 data bits so the driver can change.
// R11: only the first frame needs preamble; at least one idle bit between frames.
// R12: act only on a matching address, otherwise keep the data pin released.
// R13: upper five address bits ride in the phy field, lower five in the register field.
module srd_smi_slave
  import srd_pkg::*;
#(
  parameter logic [15:0] SIGNATURE = 16'h5a5a   // arbitrary identity value
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // management pins
  input  wire logic                  mgmt_clock_pin,
  input  wire logic                  mgmt_data_in,
  output logic                       mgmt_data_out,
  output logic                       mgmt_data_oe,
  // straps and status
  input  wire logic                  mgmt_width_strap,
  output logic                       mgmt_mode32,
  // switch events and interrupt pin
  input  wire srd_pkg::srd_events_s  events,
  output logic                       int_n,
  // access to the extended, counter and phy spaces
  output srd_pkg::srd_ext_req_s      ext_req,
  input  wire logic [15:0]           ext_rdata,
  // configuration seen by the switch core
  output logic [15:0]                cfg_sys_ctrl0
);
  import srd_pkg::*;

  srd_state_s r_reg;
  srd_state_s r_next;
  logic       mdc_rise;
  logic       bit_in;
  logic [15:0] wr_word;
  logic [15:0] rd_word;
  logic [9:0]  addr_full;

  // rising edge of the synchronised clock pin; first stage is read only by the second
  assign mdc_rise  = r_reg.mdc_s2 & ~r_reg.mdc_s3;
  assign bit_in    = r_reg.mdio_s2;
  assign wr_word   = {r_reg.shreg[14:0], bit_in};
  assign addr_full = {r_reg.addr[8:0], bit_in};
  // read data: basic space was latched at address time, outer spaces sampled now
  assign rd_word   = (r_reg.ext.region == RGN_BASIC) ? r_reg.shreg : ext_rdata;

  // next-state logic of the whole slave
  always_comb begin
    r_next = r_reg;
    r_next.ext.rd  = 1'b0;
    r_next.ext.wr  = 1'b0;
    // pin synchronisers
    r_next.mdc_s1   = mgmt_clock_pin;
    r_next.mdc_s2   = r_reg.mdc_s1;
    r_next.mdc_s3   = r_reg.mdc_s2;
    r_next.mdio_s1  = mgmt_data_in;
    r_next.mdio_s2  = r_reg.mdio_s1;
    r_next.strap_s1 = mgmt_width_strap;
    r_next.strap_s2 = r_reg.strap_s1;
    // interrupt follows any pending switch event
    r_next.int_n = ~(events.table_access | events.port_security |
                     events.counter_overflow | events.port_status); // R8
    // strap caught once, after the synchroniser has filled following reset release
    if (!r_reg.strap_taken) begin
      if (r_reg.strap_age == 2'h2) begin
        r_next.strap_taken = 1'b1;
        r_next.mode32      = r_reg.strap_s2; // R7
      end else begin
        r_next.strap_age = r_reg.strap_age + 2'h1;
      end
    end
    if (mdc_rise) begin
      case (r_reg.fsm)
        // one run of 32 ones is needed once after reset; a zero restarts the count
        ST_PRE: begin
          if (bit_in) begin
            if (r_reg.pre_cnt == PRE_LAST_BIT) begin
              r_next.pre_done = 1'b1;
              r_next.fsm      = ST_IDLE; // R11
            end else begin
              r_next.pre_cnt = r_reg.pre_cnt + 6'h01;
            end
          end else begin
            r_next.pre_cnt = 6'h00;
          end
        end
        // later frames may start without preamble
        ST_IDLE: begin
          if (!bit_in) begin
            r_next.fsm = ST_START;
          end
        end
        ST_START: begin
          if (bit_in) begin
            r_next.fsm     = ST_OPC;
            r_next.bit_cnt = 5'h00;
          end
        end
        ST_OPC: begin
          r_next.opc = {r_reg.opc[0], bit_in};
          if (r_reg.bit_cnt == OPC_LAST_BIT) begin
            r_next.fsm     = ST_ADDR;
            r_next.bit_cnt = 5'h00;
          end else begin
            r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
          end
        end
        // address arrives msb first: phy field then register field
        ST_ADDR: begin
          r_next.addr = addr_full; // R13
          if (r_reg.bit_cnt == ADDR_LAST_BIT) begin
            r_next.fsm        = ST_TA;
            r_next.bit_cnt    = 5'h00;
            r_next.is_read    = (r_reg.opc == OPC_READ);
            // unknown opcodes, unmapped addresses and 32-bit mode all leave the pin alone
            r_next.hit        = ((r_reg.opc == OPC_READ) || (r_reg.opc == OPC_WRITE)) &&
                                srd_addr_hit(addr_full) && !r_reg.mode32; // R12
            r_next.ext.addr   = addr_full; // R2
            r_next.ext.region = srd_region_of(addr_full); // R3 R4 R6
            if (r_next.hit && r_next.is_read) begin
              if (r_next.ext.region == RGN_BASIC) begin
                r_next.shreg = r_reg.cfg[addr_full[5:0]];
              end else begin
                r_next.ext.rd = 1'b1;
              end
            end
          end else begin
            r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
          end
        end
        // first turnaround bit is driven low by a reading slave, second already carries the data msb
        ST_TA: begin
          if (r_reg.bit_cnt != TA_LAST_BIT) begin
            r_next.bit_cnt = TA_LAST_BIT;
            if (r_reg.hit && r_reg.is_read) begin
              r_next.oe  = 1'b1; // R10
              r_next.out = 1'b0;
            end
          end else begin
            r_next.fsm     = ST_DATA;
            r_next.bit_cnt = 5'h00;
            if (r_reg.hit && r_reg.is_read) begin
              r_next.out   = rd_word[15];
              r_next.shreg = {rd_word[14:0], 1'b0};
            end
          end
        end
        // sixteen data bits in either direction
        ST_DATA: begin
          // a missed read keeps the data bit at rest instead of shifting stale contents
          if (r_reg.is_read && r_reg.hit) begin
            r_next.out   = r_reg.shreg[15];
            r_next.shreg = {r_reg.shreg[14:0], 1'b0};
          end else begin
            r_next.shreg = wr_word;
          end
          if (r_reg.bit_cnt == DATA_LAST_BIT) begin
            r_next.fsm = ST_GAP;
            r_next.oe  = 1'b0; // R10
            r_next.out = 1'b0;
            if (r_reg.hit && !r_reg.is_read) begin
              if (r_reg.ext.region == RGN_BASIC) begin
                // the signature word is read-only
                if (r_reg.addr[5:0] != OFS_SIGNATURE_WORD) begin
                  r_next.cfg[r_reg.addr[5:0]] = wr_word;
                end
              end else begin
                r_next.ext.wr    = 1'b1;
                r_next.ext.wdata = wr_word;
              end
            end
          end else begin
            r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
          end
        end
        // a back-to-back start without an idle one is not recognised
        ST_GAP: begin
          if (bit_in) begin
            r_next.fsm = ST_IDLE; // R11
          end
        end
        default: begin
          r_next.fsm = ST_PRE;
        end
      endcase
    end
  end

  // state register; reset loads constants only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r_reg        <= '0;
      r_reg.fsm    <= ST_PRE;
      r_reg.int_n  <= 1'b1;
      r_reg.cfg    <= {64{CFG_RESET}};
      r_reg.cfg[0] <= SIGNATURE;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign mgmt_data_out = r_reg.out;
  assign mgmt_data_oe  = r_reg.oe; // R1
  assign mgmt_mode32   = r_reg.mode32;
  assign int_n         = r_reg.int_n;
  assign ext_req       = r_reg.ext;
  assign cfg_sys_ctrl0 = r_reg.cfg[OFS_SYSTEM_CTRL_0];

  // checks on the slave's own behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  logic any_event;
  assign any_event = events.table_access | events.port_security |
                     events.counter_overflow | events.port_status;

  AST_INT_ASSERTS: assert property (any_event |=> !int_n) // R8
    else $error("interrupt not asserted after event");
  AST_INT_RELEASES: assert property (!any_event |=> int_n) // R8
    else $error("interrupt held without event");
  AST_DRIVE_ONLY_READ_HIT: assert property (mgmt_data_oe |-> (r_reg.hit && r_reg.is_read &&
                                            (r_reg.fsm == ST_TA || r_reg.fsm == ST_DATA))) // R12
    else $error("data pin driven outside a matching read");
  AST_MODE32_SILENT: assert property (mgmt_mode32 |-> !mgmt_data_oe) // R7
    else $error("data pin driven in 32-bit mode");
  AST_TA_LOW: assert property ($rose(mgmt_data_oe) |-> !mgmt_data_out && r_reg.fsm == ST_TA) // R10
    else $error("turnaround bit not driven low");
  AST_DRIVE_SPAN: assert property ($rose(mgmt_data_oe) |-> mgmt_data_oe [*8]) // R10
    else $error("read drive ended early");
  AST_DRIVE_ENDS: assert property ($fell(mgmt_data_oe) |-> r_reg.fsm == ST_GAP && $past(r_reg.bit_cnt) == 5'h0f) // R10
    else $error("read drive released off the last data bit");
  AST_EXT_READ_DECODE: assert property (ext_req.rd |-> ext_req.region == srd_region_of(ext_req.addr) &&
                                        ext_req.region != RGN_BASIC && srd_addr_hit(ext_req.addr)) // R3
    else $error("outer read with wrong space decode");
  AST_PHY_FIELD: assert property ((ext_req.rd || ext_req.wr) && ext_req.addr[9:5] == PHY_FIELD
                                  |-> ext_req.region == RGN_PHY) // R6
    else $error("phy field not decoded to phy space");
  AST_COUNTER_SPACE: assert property ((ext_req.rd || ext_req.wr) && ext_req.addr >= CNT_BEGIN &&
                                      ext_req.addr <= CNT_END |-> ext_req.region == RGN_CNT) // R4
    else $error("counter address decoded to wrong space");
  AST_EXT_WRITE_PULSE: assert property (ext_req.wr |=> !ext_req.wr) // R2
    else $error("outer write longer than one cycle");
  AST_EXT_READ_TIMING: assert property (ext_req.rd |-> r_reg.fsm == ST_TA && r_reg.bit_cnt == 5'h00) // R2
    else $error("outer read issued outside address end");
  AST_PREAMBLE_ONCE: assert property (r_reg.pre_done |=> r_reg.pre_done) // R11
    else $error("preamble flag lost");
  AST_SIGNATURE_RO: assert property (r_reg.cfg[0] == SIGNATURE) // R2
    else $error("signature word changed");

  COV_BASIC_READ: cover property ($rose(mgmt_data_oe) && r_reg.ext.region == RGN_BASIC);
  COV_EXT_READ: cover property (ext_req.rd ##[1:400] $rose(mgmt_data_oe));
  COV_PHY_WRITE: cover property (ext_req.wr && ext_req.region == RGN_PHY);
  COV_MISS_FRAME: cover property (r_reg.fsm == ST_DATA && !r_reg.hit);

endmodule : srd_smi_slave

`default_nettype wire

// >>> test/srd_host_model.sv
// behavioural management master that clocks frames onto the shared data wire
`timescale 1ns/100ps
`default_nettype none

module srd_host_model
  import srd_pkg::*;
(
  // bench clock, used to pace the management clock and to time the one-cycle result strobe
  input  wire logic        ref_clk,
  // resolved level of the data wire
  input  wire logic        wire_lvl,
  // management pins driven by the host
  output logic             mdc,
  output logic             host_out,
  output logic             host_oe,
  // sampled turnaround level and read data of the last frame
  output logic             res_valid,
  output logic [16:0]      res_data
);
  initial begin
    mdc       = 1'b0;
    host_out  = 1'b0;
    host_oe   = 1'b0;
    res_valid = 1'b0;
    res_data  = '0;
  end

  // one bit: data changes with the clock low, the wire is sampled at the end of the high phase
  task automatic clk_bit(input logic drv, input logic b, output logic smp);
    host_oe  = drv;
    host_out = b;
    repeat (10) @(negedge ref_clk);
    mdc = 1'b1;
    repeat (10) @(negedge ref_clk);
    smp = wire_lvl;
    mdc = 1'b0;
  endtask : clk_bit

  // whole frame; the clock stands low once the trailing idle bit is sent
  task automatic xfer(input bit pre, input logic [1:0] op, input logic [9:0] a, input logic [15:0] wd);
    logic        s;
    logic        wr;
    logic [13:0] hdr;
    logic [17:0] tail;
    logic [17:0] sh;
    wr   = (op == OPC_WRITE);
    hdr  = {2'b01, op, a};
    tail = {2'b10, wd};
    if (pre) begin
      for (int i = 0; i < 32; i++) clk_bit(1'b1, 1'b1, s);
    end
    for (int i = 13; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
    // on reads the host lets go so the device can take over the wire
    for (int i = 17; i >= 0; i--) begin
      clk_bit(wr, tail[i], s);
      sh[i] = s;
    end
    clk_bit(1'b0, 1'b1, s);
    host_oe = 1'b0;
    if (!wr) begin
      res_data  = sh[17:1];
      res_valid = 1'b1;
      @(negedge ref_clk);
      res_valid = 1'b0;
    end
  endtask : xfer
endmodule : srd_host_model

`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench of the serial management slave
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import srd_pkg::*;

  logic          ref_clk;
  logic          resetn;
  logic          strap;
  logic          mdc;
  logic          host_out;
  logic          host_oe;
  logic          res_valid;
  logic [16:0]   res_data;
  logic          dut_out;
  logic          dut_oe;
  logic          mode32;
  logic          int_n;
  logic [15:0]   ext_rdata;
  logic [15:0]   cfg0;
  logic [15:0]   d;
  logic [31:0]   r;
  srd_events_s   events;
  srd_ext_req_s  ext_req;
  logic [31:0]   exp_q[$];
  int            error_cnt;
  int            compares;
  logic [9:0]    ext_a[6] = '{10'h040, 10'h09b, 10'h0a0, 10'h143, {5'b10000, 5'h01}, 10'h2ff};
  logic [1:0]    ext_g[6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [9:0]    bad_a[4] = '{10'h09c, 10'h144, 10'h1ff, 10'h300};

  // pull-up holds the wire high whenever nobody drives it
  wire data_lvl = dut_oe ? dut_out : (host_oe ? host_out : 1'b1);

  always #4 ref_clk = ~ref_clk;

  srd_smi_slave dut (
    .ref_clk(ref_clk), .resetn(resetn), .mgmt_clock_pin(mdc), .mgmt_data_in(data_lvl),
    .mgmt_data_out(dut_out), .mgmt_data_oe(dut_oe), .mgmt_width_strap(strap), .mgmt_mode32(mode32),
    .events(events), .int_n(int_n), .ext_req(ext_req), .ext_rdata(ext_rdata), .cfg_sys_ctrl0(cfg0)
  );

  srd_host_model host (
    .ref_clk(ref_clk), .wire_lvl(data_lvl), .mdc(mdc), .host_out(host_out), .host_oe(host_oe),
    .res_valid(res_valid), .res_data(res_data)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // every result that shows up must match the oldest note
  task automatic take(input logic [31:0] seen);
    if (exp_q.size() == 0) begin
      error_cnt++;
      $display("MISMATCH at %0t: unexpected result %h", $time, seen);
    end else begin
      check(seen, exp_q.pop_front());
    end
  endtask : take

  always @(posedge ref_clk) begin
    if (res_valid) take({15'h0, res_data});
    if (ext_req.rd || ext_req.wr) take({ext_req.region, ext_req.addr, 2'b0, ext_req.rd, ext_req.wr,
                                        ext_req.wr ? ext_req.wdata : 16'h0000});
  end

  // read notes the turnaround level and data expected back at the host
  task automatic rd(input bit pre, input logic [1:0] op, input logic [9:0] a, input logic [16:0] e);
    exp_q.push_back({15'h0, e});
    host.xfer(pre, op, a, 16'h0000);
  endtask : rd

  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // 31 frames of some 660 cycles each, two with preamble of some 1300; the limit leaves room but stays under 100k cycles
  initial begin
    #700us;
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    ref_clk   = 1'b0;
    resetn    = 1'b0;
    strap     = 1'b0;
    events    = '0;
    ext_rdata = 16'h0000;
    error_cnt = 0;
    compares  = 0;
    r = $urandom(32'h7f0b679f);
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (5) @(negedge ref_clk);
    check({int_n, mode32, dut_oe, cfg0, ext_req.rd, ext_req.wr}, {3'b100, 16'h0000, 2'b00});
    rd(0, OPC_READ, 10'h000, 17'h1ffff);
    rd(1, OPC_READ, 10'h000, {1'b0, 16'h5a5a});
    d = 16'($urandom);
    host.xfer(0, OPC_WRITE, 10'h00a, d);
    check(cfg0, d);
    rd(0, OPC_READ, 10'h00a, {1'b0, d});
    host.xfer(0, OPC_WRITE, 10'h000, 16'hffff);
    rd(0, OPC_READ, 10'h000, {1'b0, 16'h5a5a});
    d = 16'($urandom);
    host.xfer(0, OPC_WRITE, 10'h02d, d);
    rd(0, OPC_READ, 10'h02d, {1'b0, d});
    // outer spaces: boundary addresses of each, 0x201 in place of the phy low end, read then written
    for (int i = 0; i < 6; i++) begin
      ext_rdata = 16'($urandom);
      exp_q.push_back({ext_g[i], ext_a[i], 4'b0010, 16'h0000});
      rd(0, OPC_READ, ext_a[i], {1'b0, ext_rdata});
      d = 16'($urandom);
      exp_q.push_back({ext_g[i], ext_a[i], 4'b0001, d});
      host.xfer(0, OPC_WRITE, ext_a[i], d);
    end
    // holes between the spaces and above the phy space leave the pin released and start no access
    for (int i = 0; i < 4; i++) begin
      rd(0, OPC_READ, bad_a[i], 17'h1ffff);
      host.xfer(0, OPC_WRITE, bad_a[i], 16'h1234);
    end
    rd(0, 2'b00, 10'h00a, 17'h1ffff);
    rd(0, 2'b11, 10'h00a, 17'h1ffff);
    for (int i = 0; i < 4; i++) begin
      events = srd_events_s'(4'h1 << i);
      @(negedge ref_clk);
      check({31'h0, int_n}, 32'h0);
      events = '0;
      @(negedge ref_clk);
      check({31'h0, int_n}, 32'h1);
    end
    // strap high at reset selects the unsupported wide mode, so the slave stays silent
    strap  = 1'b1;
    resetn = 1'b0;
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (5) @(negedge ref_clk);
    check({31'h0, mode32}, 32'h1);
    rd(1, OPC_READ, 10'h000, 17'h1ffff);
    repeat (4) @(negedge ref_clk);
    check(32'(exp_q.size()), 32'h0);
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
